// >>> bench/obcr_casc_src.sv
// far-side model: a preceding device feeding its bus a/b samples into our cascade pins
// assumes the bench enables it only while the block has released buses c and d
`timescale 1ns/10ps
`default_nettype none
module obcr_casc_src (
    input wire logic core_clk,
    input wire logic drive_en,
    output logic [19:0] cas_i,
    output logic [19:0] cas_q
);
    initial begin
        cas_i = 20'h5A5A5;
        cas_q = 20'hA5A5A;
    end
    // fresh samples each rising edge; released pins toggle so stale data never matches
    always @(posedge core_clk) begin
        if (drive_en) begin
            cas_i <= 20'($urandom);
            cas_q <= 20'($urandom);
        end else begin
            cas_i <= ~cas_i;
            cas_q <= ~cas_q;
        end
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the output routing block with a cascade source model
// assumes the hand-over latencies: results two edges after push, cascade one edge
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import obcr_pkg::*;
    typedef struct {obcr_quad_t i; obcr_quad_t q; int due;} obcr_exp_t;
    logic core_clk = 1'b0, rst = 1'b1, sync_pol = 1'b1, sync_req = 1'b0, upd_pol = 1'b1;
    logic upd_mask = 1'b0, channel_update_in = 1'b0, res_valid = 1'b0;
    logic [1:0] out_mode = OBCR_MODE_NORMAL;
    obcr_quad_t res_data = '0, res_q_data = '0, pq;
    logic cfg_load, res_ready, c_oe, d_oe, i_phase_strobe, sync_out, stalled = 1'b0;
    logic [19:0] out_bus_a, out_bus_b, c_out, d_out, casc_i_to_sum1, casc_q_to_sum2;
    logic [19:0] cas_i, cas_q, pin_c, pin_d;
    logic [39:0] prev;
    logic loop_sync = 1'b0, upd_pin;
    int num_errors = 0, comparisons = 0, cyc = 0, cnt;
    bit mux = 0, q_pend = 0;
    obcr_exp_t exq[$], e;
    // wire level of the shared pins: the block wins while it drives
    assign pin_c = c_oe ? c_out : cas_i;
    assign pin_d = d_oe ? d_out : cas_q;
    // a master's sync output wired to this channel's update pin, as the system does
    assign upd_pin = loop_sync ? sync_out : channel_update_in;
    obcr_top obcr_top_i (.core_clk, .rst, .out_mode, .sync_pol, .sync_req, .upd_pol,
        .upd_mask, .channel_update_in(upd_pin), .cfg_load, .res_valid, .res_ready, .res_data,
        .res_q_data, .out_bus_a, .out_bus_b, .i_cascade_in_or_bus_c_in(pin_c),
        .i_cascade_in_or_bus_c_out(c_out), .i_cascade_in_or_bus_c_oe(c_oe),
        .q_cascade_in_or_bus_d_in(pin_d), .q_cascade_in_or_bus_d_out(d_out),
        .q_cascade_in_or_bus_d_oe(d_oe), .casc_i_to_sum1, .casc_q_to_sum2,
        .i_phase_strobe, .sync_out);
    obcr_casc_src obcr_casc_src_i (.core_clk, .drive_en(out_mode == OBCR_MODE_CASCADE_IN && !c_oe),
        .cas_i, .cas_q);
    initial forever #50 core_clk = ~core_clk;
    task automatic chk(input string n, input logic [79:0] ex, input logic [79:0] g);
        comparisons++;
        if (g !== ex) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, ex, g);
        end
    endtask
    task automatic conclude;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    function automatic obcr_quad_t rq;
        rq = 80'({$urandom, $urandom, $urandom});
    endfunction
    // holds the request until ready was seen high, then notes what must come out
    task automatic push(input obcr_quad_t i, input obcr_quad_t q);
        int k;
        res_valid <= 1'b1;
        res_data <= i;
        res_q_data <= q;
        for (k = 0; k < 100; k++) begin
            @(negedge core_clk);
            if (res_ready === 1'b1) break;
            stalled = 1'b1;
        end
        if (k == 100) begin
            num_errors++;
            conclude();
        end
        @(posedge core_clk);
        e.i = i;
        e.q = q;
        e.due = cyc + 2;
        exq.push_back(e);
    endtask
    task automatic drain;
        for (int k = 0; k < 200 && exq.size() > 0; k++) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk("pending", 0, exq.size());
        if (exq.size() != 0) conclude();
    endtask
    // monitor: muxed results are keyed on the strobe, plain ones on their due cycle
    always @(negedge core_clk) begin
        cyc++;
        if (q_pend) begin
            chk("bus_q", pq, {out_bus_a, out_bus_b, c_out, d_out});
            chk("strobe_q", 0, i_phase_strobe);
            q_pend = 0;
        end else if (exq.size() > 0 && (mux ? i_phase_strobe === 1'b1 : exq[0].due == cyc)) begin
            e = exq.pop_front();
            chk("bus_i", e.i, {out_bus_a, out_bus_b, c_out, d_out});
            if (!mux) chk("strobe", 0, i_phase_strobe);
            q_pend = mux;
            pq = e.q;
        end
    end
    initial begin
        #(100000 * 100);
        num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(27));
        // reset is sampled high at four edges: three here and the one that drops it
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("reset", 0, {out_bus_a, c_oe, d_oe, i_phase_strobe, sync_out});
        @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        // back-to-back plain results
        repeat (6) push(rq(), rq());
        res_valid <= 1'b0;
        drain();
        chk("oe_out", 2'h3, {c_oe, d_oe});
        // muxed i/q pushed faster than it drains, so the fifo must refuse
        out_mode <= OBCR_MODE_MUX_IQ;
        mux = 1;
        repeat (40) push(rq(), rq());
        res_valid <= 1'b0;
        drain();
        chk("stalled", 1, stalled);
        mux = 0;
        // cascade-in: pins released, samples passed on one edge later
        out_mode <= OBCR_MODE_CASCADE_IN;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        chk("oe_in", 0, {c_oe, d_oe});
        prev = {pin_c, pin_d};
        repeat (8) begin
            @(negedge core_clk);
            chk("casc", prev, {casc_i_to_sum1, casc_q_to_sum2});
            prev = {pin_c, pin_d};
        end
        @(posedge core_clk);
        out_mode <= OBCR_MODE_NORMAL;
        // every polarity and request level of the sync output
        for (int p = 0; p < 2; p++) begin
            for (int r = 0; r < 2; r++) begin
                @(posedge core_clk);
                sync_pol <= 1'(p);
                sync_req <= 1'(r);
                @(posedge core_clk);
                @(negedge core_clk);
                chk("sync", r ? p : !p, sync_out);
            end
        end
        // update input of each polarity, masked and unmasked: one load or none
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 2; m++) begin
                @(posedge core_clk);
                upd_pol <= 1'(p);
                upd_mask <= 1'(m);
                channel_update_in <= !p;
                repeat (3) @(posedge core_clk);
                channel_update_in <= 1'(p);
                cnt = 0;
                repeat (4) begin
                    @(negedge core_clk);
                    if (cfg_load === 1'b1) cnt++;
                end
                chk("cfg_load", m, cnt);
            end
        end
        // master-to-slave sync: our own sync output drives the update pin
        @(posedge core_clk);
        sync_pol <= 1'b1;
        upd_pol <= 1'b1;
        upd_mask <= 1'b1;
        sync_req <= 1'b0;
        loop_sync <= 1'b1;
        repeat (3) @(posedge core_clk);
        sync_req <= 1'b1;
        cnt = 0;
        repeat (5) begin
            @(negedge core_clk);
            if (cfg_load === 1'b1) cnt++;
        end
        chk("sync_to_update", 1, cnt);
        conclude();
    end
endmodule
`default_nettype wire

// >>> verilog/obcr_fifo.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module obcr_fifo #(
    parameter int WIDTH = 80,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic ready_r, ready_nxt;
    logic push, pop;

    // pointer and count update; full stalls the producer
    always_comb begin
        push = in_valid && ready_r;
        pop = out_ready && (cnt_r != '0);
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        // ready is precomputed so the producer sees a flop, not a compare
        ready_nxt = (cnt_nxt != FULL_CNT);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            ready_r <= 1'b1;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            ready_r <= ready_nxt;
        end
    end

    // storage has no reset; only written entries are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end

    assign in_ready = ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
endmodule
`default_nettype wire

// >>> verilog/obcr_pkg.sv
// package for the output bus cascade routing block: widths, modes and carriers
// assumes a single rising-edge device clock shared by every user
package obcr_pkg;
    localparam int OBCR_SAMPLE_W = 20;
    localparam int OBCR_FIFO_DEPTH = 16;
    localparam int OBCR_CLK_MHZ = 10;
    // output mode encoding on the mode input
    localparam logic [1:0] OBCR_MODE_NORMAL = 2'h0;
    localparam logic [1:0] OBCR_MODE_CASCADE_IN = 2'h1;
    localparam logic [1:0] OBCR_MODE_MUX_IQ = 2'h2;
    // reset values of the driven buses and of the sync output polarity
    localparam logic [19:0] OBCR_BUS_RESET = 20'h00000;
    localparam logic OBCR_SYNC_POL_RESET = 1'h1;

    // one set of results from the four summer/formatters
    typedef struct packed {
        logic [19:0] s1;
        logic [19:0] s2;
        logic [19:0] s3;
        logic [19:0] s4;
    } obcr_quad_t;

    // a two-way 20-bit bus at the pin: output and output enable
    typedef struct packed {
        logic [19:0] dout;
        logic oe;
    } obcr_pin_t;
endpackage

// >>> verilog/obcr_top.sv
// output side routing: buses a-d, cascade inputs, i strobe and sync output
// assumes summer/formatter results arrive as one stream of four samples,
// and that the output mode and polarity settings are static inputs
`timescale 1ns/10ps
`default_nettype none
// How it works
// - sync_out follows the sync_req level one edge later, with its active level set by sync_pol.
// - out_bus_a shows summer 1 samples, registered on the rising edge, bit 19 msb.
// - out_bus_b shows summer 2 samples, registered on the rising edge, bit 19 msb.
// - bus c is an input in cascade-in mode and is driven in every other mode.
// - bus d is an input in cascade-in mode and is driven in every other mode.
// - in cascade-in the bus c input is sampled each edge and passed toward summer 1.
// - in cascade-in the bus d input is sampled each edge and passed toward summer 2.
// - in muxed i/q mode i_phase_strobe is high exactly while the buses hold i data.
// - an update input edge of the chosen polarity loads config only if masked in.
module obcr_top
    import obcr_pkg::*;
#(
    parameter int SAMPLE_W = OBCR_SAMPLE_W,
    parameter int FIFO_DEPTH = OBCR_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] out_mode,
    input wire logic sync_pol,
    input wire logic sync_req,
    input wire logic upd_pol,
    input wire logic upd_mask,
    input wire logic channel_update_in,
    output logic cfg_load,
    input wire logic res_valid,
    output logic res_ready,
    input wire obcr_quad_t res_data,
    input wire obcr_quad_t res_q_data,
    output logic [19:0] out_bus_a,
    output logic [19:0] out_bus_b,
    input wire logic [19:0] i_cascade_in_or_bus_c_in,
    output logic [19:0] i_cascade_in_or_bus_c_out,
    output logic i_cascade_in_or_bus_c_oe,
    input wire logic [19:0] q_cascade_in_or_bus_d_in,
    output logic [19:0] q_cascade_in_or_bus_d_out,
    output logic q_cascade_in_or_bus_d_oe,
    output logic [19:0] casc_i_to_sum1,
    output logic [19:0] casc_q_to_sum2,
    output logic i_phase_strobe,
    output logic sync_out
);
    typedef enum logic [1:0] {OBCR_IDLE, OBCR_I_PHASE, OBCR_Q_PHASE} obcr_state_t;

    // i and q results travel together so a q word always pairs with its i
    logic [159:0] f_out;
    logic f_valid, f_pop;
    obcr_quad_t fi, fq;

    obcr_fifo #(.WIDTH(160), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .in_valid(res_valid),
        .in_ready(res_ready),
        .in_data({res_data, res_q_data}),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_out)
    );
    assign fi = f_out[159:80];
    assign fq = f_out[79:0];

    function automatic logic is_mode(input logic [1:0] m, input logic [1:0] want);
        return m == want;
    endfunction

    obcr_state_t st_r, st_nxt;
    logic [19:0] a_r, a_nxt, b_r, b_nxt, c_r, c_nxt, d_r, d_nxt;
    logic c_oe_r, c_oe_nxt, stb_r, stb_nxt;
    obcr_quad_t q_hold_r, q_hold_nxt;
    logic [19:0] ci_r, ci_nxt, cq_r, cq_nxt;
    logic sync_r, sync_nxt, upd_d_r, upd_d_nxt, load_r, load_nxt;
    logic casc, mux;

    // output path: pop one result set, show it, and in muxed mode follow with q
    always_comb begin
        casc = is_mode(out_mode, OBCR_MODE_CASCADE_IN);
        mux = is_mode(out_mode, OBCR_MODE_MUX_IQ);
        st_nxt = st_r;
        a_nxt = a_r;
        b_nxt = b_r;
        c_nxt = c_r;
        d_nxt = d_r;
        stb_nxt = 1'b0;
        q_hold_nxt = q_hold_r;
        f_pop = 1'b0;
        c_oe_nxt = !casc;
        case (st_r)
            OBCR_IDLE, OBCR_Q_PHASE, OBCR_I_PHASE: begin
                if (mux && st_r == OBCR_I_PHASE) begin
                    // q half of the pair, no pop so the fifo holds back
                    a_nxt = q_hold_r.s1;
                    b_nxt = q_hold_r.s2;
                    c_nxt = q_hold_r.s3;
                    d_nxt = q_hold_r.s4;
                    st_nxt = OBCR_Q_PHASE;
                end else if (f_valid) begin
                    f_pop = 1'b1;
                    a_nxt = fi.s1;
                    b_nxt = fi.s2;
                    c_nxt = fi.s3;
                    d_nxt = fi.s4;
                    q_hold_nxt = fq;
                    stb_nxt = mux;
                    st_nxt = mux ? OBCR_I_PHASE : OBCR_IDLE;
                end else begin
                    st_nxt = OBCR_IDLE;
                end
            end
            default: st_nxt = OBCR_IDLE;
        endcase
    end

    // cascade capture, sync output and update-input edge detect
    always_comb begin
        ci_nxt = casc ? i_cascade_in_or_bus_c_in : ci_r;
        cq_nxt = casc ? q_cascade_in_or_bus_d_in : cq_r;
        sync_nxt = sync_req ? sync_pol : !sync_pol;
        upd_d_nxt = (channel_update_in == upd_pol);
        // a level held active loads once; the mask gates the load
        load_nxt = upd_d_nxt && !upd_d_r && upd_mask;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_r <= OBCR_IDLE;
            a_r <= OBCR_BUS_RESET;
            b_r <= OBCR_BUS_RESET;
            c_r <= OBCR_BUS_RESET;
            d_r <= OBCR_BUS_RESET;
            c_oe_r <= 1'b0;
            stb_r <= 1'b0;
            q_hold_r <= '0;
            ci_r <= OBCR_BUS_RESET;
            cq_r <= OBCR_BUS_RESET;
            sync_r <= !OBCR_SYNC_POL_RESET;
            upd_d_r <= 1'b0;
            load_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            a_r <= a_nxt;
            b_r <= b_nxt;
            c_r <= c_nxt;
            d_r <= d_nxt;
            c_oe_r <= c_oe_nxt;
            stb_r <= stb_nxt;
            q_hold_r <= q_hold_nxt;
            ci_r <= ci_nxt;
            cq_r <= cq_nxt;
            sync_r <= sync_nxt;
            upd_d_r <= upd_d_nxt;
            load_r <= load_nxt;
        end
    end

    assign out_bus_a = a_r;
    assign out_bus_b = b_r;
    assign i_cascade_in_or_bus_c_out = c_r;
    assign q_cascade_in_or_bus_d_out = d_r;
    assign i_cascade_in_or_bus_c_oe = c_oe_r;
    assign q_cascade_in_or_bus_d_oe = c_oe_r;
    assign casc_i_to_sum1 = ci_r;
    assign casc_q_to_sum2 = cq_r;
    assign i_phase_strobe = stb_r;
    assign sync_out = sync_r;
    assign cfg_load = load_r;

    // checks, kept beside the logic
    AST_SYNC_POL: assert property (@(posedge core_clk) disable iff (rst)
        !rst |=> sync_out == ($past(sync_req) ? $past(sync_pol) : !$past(sync_pol)))
        else $error("sync_out level wrong");
    AST_BUS_A: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && f_pop && !mux) |=> out_bus_a == $past(fi.s1))
        else $error("bus a not summer 1");
    AST_BUS_B: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && f_pop && !mux) |=> out_bus_b == $past(fi.s2))
        else $error("bus b not summer 2");
    AST_C_DIR: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && casc) |=> !i_cascade_in_or_bus_c_oe)
        else $error("bus c driven in cascade-in");
    AST_D_DIR: assert property (@(posedge core_clk) disable iff (rst)
        // the enable comes back one edge after reset, so the reset edge is left out
        (!rst && !casc) |=> q_cascade_in_or_bus_d_oe)
        else $error("bus d not driven");
    AST_CASC_I: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && casc) |=> casc_i_to_sum1 == $past(i_cascade_in_or_bus_c_in))
        else $error("cascade i not captured");
    AST_CASC_Q: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && casc) |=> casc_q_to_sum2 == $past(q_cascade_in_or_bus_d_in))
        else $error("cascade q not captured");
    AST_BUS_C: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && f_pop) |=> i_cascade_in_or_bus_c_out == $past(fi.s3))
        else $error("bus c not summer 3");
    AST_BUS_D: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && f_pop) |=> q_cascade_in_or_bus_d_out == $past(fi.s4))
        else $error("bus d not summer 4");
    AST_STROBE_I: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && mux && f_pop) |=> i_phase_strobe ##1 !i_phase_strobe)
        else $error("i strobe timing wrong");
    AST_UPD_MASK: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && !upd_mask) |=> !cfg_load)
        else $error("load while masked");
    AST_Q_PAIR: assert property (@(posedge core_clk) disable iff (rst)
        (!rst && mux && f_pop) ##1 mux |=> out_bus_a == $past(q_hold_r.s1, 1))
        else $error("q half not paired");
    COV_MUX: cover property (@(posedge core_clk) mux && f_pop ##1 i_phase_strobe ##1 1'b1);
    COV_CASC: cover property (@(posedge core_clk) casc && res_valid);
    COV_LOAD: cover property (@(posedge core_clk) cfg_load);
    COV_FULL: cover property (@(posedge core_clk) res_valid && !res_ready);
endmodule
`default_nettype wire
